// *** hw/lbm_pkg.sv ***
// Purpose: constants, types and register map of the LED boost mode controller
// Assumes: core_clk at 250 MHz; all times converted to cycles here
// Notes: reference levels are carried in millivolts
package lbm_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CLK_KHZ = CLK_MHZ * 1000;
    localparam int SW_FREQ_KHZ = 1200;
    localparam logic [7:0] SW_DIV_CYC = 8'(CLK_KHZ / SW_FREQ_KHZ);
    localparam logic [2:0] OVP_RUN_LAST = 3'h7;

    localparam int LOW_TO_SHUTDOWN_US = 2500;
    localparam int ENABLE_TO_BACKLIGHT_US = 6000;
    localparam int FLASH_ENTRY_US = 50;
    localparam int FLASH_EXIT_US = 50;
    localparam int FLASH_LIMIT_MS = 320;
    localparam int COOLDOWN_MS = 960;
    localparam int LOW_TO_SHUTDOWN_CYC = LOW_TO_SHUTDOWN_US * CLK_MHZ;
    localparam int ENABLE_TO_BACKLIGHT_CYC = ENABLE_TO_BACKLIGHT_US * CLK_MHZ;
    localparam int FLASH_ENTRY_CYC = FLASH_ENTRY_US * CLK_MHZ;
    localparam int FLASH_EXIT_CYC = FLASH_EXIT_US * CLK_MHZ;
    localparam int FLASH_LIMIT_CYC = FLASH_LIMIT_MS * CLK_KHZ;
    localparam int COOLDOWN_CYC = COOLDOWN_MS * CLK_KHZ;
    localparam logic [1:0] TIMER_UP_STEP = 2'h3;

    localparam logic [15:0] BACKLIGHT_FS_MV = 16'h00C8;
    localparam logic [15:0] FLASH_FS_MV = 16'h03E8;
    localparam int FILTER_STEP_NS = 1000;
    localparam logic [7:0] FILTER_DIV_CYC = 8'(FILTER_STEP_NS * CLK_MHZ / 1000);

    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_FLASH_TIMER = 4'h8;
    localparam logic [3:0] REG_COOLDOWN = 4'hC;
    localparam logic [3:0] CFG_SHIFT_RESET = 4'h9;
    localparam int STATUS_STATE_POS = 8;

    typedef enum logic [2:0] {
        ST_OFF, ST_START, ST_BL, ST_FL_ENTER, ST_FL, ST_FL_EXIT, ST_STANDBY, ST_FAULT
    } lbm_state_t;

    typedef struct packed {
        logic dim_en;
        logic flash_trig;
        logic ovp_cmp;
        logic uvlo;
        logic over_temp;
        logic flash_supply_lockout;
    } lbm_pins_t;

    typedef struct packed {
        logic switch_en;
        logic soft_start;
        logic flash_mode;
        logic standby;
        logic open_led_fault;
        logic cooldown;
    } lbm_status_t;
endpackage : lbm_pkg

// *** hw/lbm_ref_filter.sv ***
// Purpose: first-order low-pass filter of the chopped feedback reference
// Assumes: target changes at the PWM rate; filter steps once per microsecond
// Notes: shift sets the time constant, 2^shift steps
`timescale 1ns/1ps
`default_nettype none
module lbm_ref_filter
    import lbm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // chopped target and filter setting
    input wire logic [15:0] target,
    input wire logic [3:0] shift,
    // filtered feedback target in millivolts
    output logic [15:0] level
);
    logic [7:0] div_reg, div_next;
    logic [31:0] acc_reg, acc_next;
    logic signed [32:0] diff;

    always_comb begin
        div_next = (div_reg == FILTER_DIV_CYC - 8'h01) ? 8'h00 : div_reg + 8'h01;
        diff = $signed({1'b0, target, 16'h0000}) - $signed({1'b0, acc_reg});
        acc_next = acc_reg;
        if (div_reg == 8'h00) begin
            acc_next = acc_reg + 32'(diff >>> shift);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
            acc_reg <= 32'h0000_0000;
        end else begin
            div_reg <= div_next;
            acc_reg <= acc_next;
        end
    end

    assign level = acc_reg[31:16];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_filter_hold: assert property (div_reg != 8'h00 |=> $stable(acc_reg))
        else $error("filter moved between steps");
    a_filter_rise: assert property (div_reg == 8'h00 && diff > 33'sd0 && shift < 4'hF
        |=> acc_reg >= $past(acc_reg))
        else $error("filter moved away from a higher target");
endmodule : lbm_ref_filter
`default_nettype wire

// *** hw/lbm_controller.sv ***
// Purpose: mode, protection and reference control of an LED boost driver
// Assumes: pins are asynchronous to core_clk; host keeps its PWM in range
// Notes: registers: 0x0 filter setting, 0x4 status, 0x8 flash timer, 0xC cool-down
`timescale 1ns/1ps
`default_nettype none
module lbm_controller
    import lbm_pkg::*;
#(
    parameter logic [31:0] LOW_DELAY_CYC = 32'(LOW_TO_SHUTDOWN_CYC),
    parameter logic [31:0] START_DELAY_CYC = 32'(ENABLE_TO_BACKLIGHT_CYC),
    parameter logic [31:0] ENTRY_DELAY_CYC = 32'(FLASH_ENTRY_CYC),
    parameter logic [31:0] EXIT_DELAY_CYC = 32'(FLASH_EXIT_CYC),
    parameter logic [31:0] FLASH_LIMIT = 32'(FLASH_LIMIT_CYC),
    parameter logic [31:0] COOL_DELAY_CYC = 32'(COOLDOWN_CYC)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // asynchronous pins and analog indications
    input wire lbm_pkg::lbm_pins_t pins,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // power stage control
    output lbm_pkg::lbm_status_t status,
    output logic [15:0] full_scale_mv,
    output logic [15:0] reference_level
);
    localparam logic [31:0] TIMER_LIMIT = FLASH_LIMIT * 32'h3;

    // two-stage synchroniser for every pin
    lbm_pins_t sync1_reg, sync2_reg, sync_prev_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync_prev_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    logic dim_s, trig_s, ovp_s, uvlo_s, otp_s, lock_s, trig_rise;
    assign dim_s = sync2_reg.dim_en;
    assign trig_s = sync2_reg.flash_trig;
    assign ovp_s = sync2_reg.ovp_cmp;
    assign uvlo_s = sync2_reg.uvlo;
    assign otp_s = sync2_reg.over_temp;
    assign lock_s = sync2_reg.flash_supply_lockout;
    assign trig_rise = trig_s && !sync_prev_reg.flash_trig;

    lbm_state_t state_reg, state_next;
    logic [7:0] sw_div_reg, sw_div_next;
    logic [2:0] ovp_run_reg, ovp_run_next;
    logic [31:0] low_cnt_reg, low_cnt_next;
    logic [31:0] phase_reg, phase_next;
    logic [31:0] ftimer_reg, ftimer_next;
    logic [31:0] cool_reg, cool_next;
    logic seen_low_reg, seen_low_next;
    logic sw_tick, ovp_trip, low_expired, in_flash, active, at_limit;

    always_comb begin
        sw_tick = (sw_div_reg == SW_DIV_CYC - 8'h01);
        sw_div_next = sw_tick ? 8'h00 : sw_div_reg + 8'h01;
        active = (state_reg == ST_START) || (state_reg == ST_BL) || (state_reg == ST_FL_ENTER)
            || (state_reg == ST_FL) || (state_reg == ST_FL_EXIT);
        in_flash = (state_reg == ST_FL_ENTER) || (state_reg == ST_FL) || (state_reg == ST_FL_EXIT);
        ovp_trip = active && sw_tick && ovp_s && (ovp_run_reg == OVP_RUN_LAST);
        low_expired = !dim_s && (low_cnt_reg >= LOW_DELAY_CYC);
        at_limit = (ftimer_reg >= TIMER_LIMIT);

        ovp_run_next = ovp_run_reg;
        if (!active) begin
            ovp_run_next = 3'h0;
        end else if (sw_tick) begin
            ovp_run_next = ovp_s ? ovp_run_reg + 3'h1 : 3'h0;
        end

        low_cnt_next = dim_s ? 32'h0 : (low_expired ? low_cnt_reg : low_cnt_reg + 32'h1);

        // timer in thirds: +3 while the trigger is high in flash, -1 while low
        ftimer_next = ftimer_reg;
        if (state_reg == ST_OFF || state_reg == ST_FAULT) begin
            ftimer_next = 32'h0;
        end else if (trig_s && in_flash) begin
            ftimer_next = at_limit ? ftimer_reg : ftimer_reg + 32'(TIMER_UP_STEP);
        end else if (!trig_s && ftimer_reg != 32'h0) begin
            ftimer_next = ftimer_reg - 32'h1;
        end

        cool_next = (cool_reg != 32'h0) ? cool_reg - 32'h1 : 32'h0;
        seen_low_next = (state_reg == ST_FAULT) && (seen_low_reg || !dim_s);
        phase_next = phase_reg + 32'h1;
        state_next = state_reg;

        if (state_reg == ST_FAULT) begin
            if (seen_low_reg && dim_s && !uvlo_s && !otp_s) begin
                state_next = ST_START;
            end
        end else if (uvlo_s || otp_s) begin
            state_next = ST_OFF;
        end else if (ovp_trip) begin
            state_next = ST_FAULT;
        end else if (active && low_expired) begin
            state_next = ST_STANDBY;
        end else if (in_flash && at_limit) begin
            state_next = ST_BL;
            cool_next = COOL_DELAY_CYC;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (dim_s) begin
                        state_next = ST_START;
                    end
                end
                ST_START: begin
                    if (phase_reg >= START_DELAY_CYC - 32'h1) begin
                        state_next = ST_BL;
                    end
                end
                ST_BL: begin
                    if (trig_rise && !lock_s && cool_reg == 32'h0) begin
                        state_next = ST_FL_ENTER;
                    end
                end
                ST_FL_ENTER: begin
                    if (!trig_s) begin
                        state_next = ST_FL_EXIT;
                    end else if (phase_reg >= ENTRY_DELAY_CYC - 32'h1) begin
                        state_next = ST_FL;
                    end
                end
                ST_FL: begin
                    if (!trig_s) begin
                        state_next = ST_FL_EXIT;
                    end
                end
                ST_FL_EXIT: begin
                    if (trig_s) begin
                        state_next = ST_FL;
                    end else if (phase_reg >= EXIT_DELAY_CYC - 32'h1) begin
                        state_next = ST_BL;
                    end
                end
                ST_STANDBY: begin
                    if (dim_s) begin
                        state_next = ST_BL;
                    end else if (ftimer_reg == 32'h0) begin
                        state_next = ST_OFF;
                    end
                end
                default: begin
                    state_next = ST_OFF;
                end
            endcase
        end
        if (state_next != state_reg) begin
            phase_next = 32'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_OFF;
            sw_div_reg <= 8'h00;
            ovp_run_reg <= 3'h0;
            low_cnt_reg <= 32'h0;
            phase_reg <= 32'h0;
            ftimer_reg <= 32'h0;
            cool_reg <= 32'h0;
            seen_low_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sw_div_reg <= sw_div_next;
            ovp_run_reg <= ovp_run_next;
            low_cnt_reg <= low_cnt_next;
            phase_reg <= phase_next;
            ftimer_reg <= ftimer_next;
            cool_reg <= cool_next;
            seen_low_reg <= seen_low_next;
        end
    end

    // outputs registered from the next state
    lbm_status_t status_reg, status_next;
    logic [15:0] fs_reg, fs_next, chop_reg, chop_next;
    logic next_switching, next_flash;
    always_comb begin
        next_switching = (state_next == ST_START) || (state_next == ST_BL) || (state_next == ST_FL_ENTER)
            || (state_next == ST_FL) || (state_next == ST_FL_EXIT);
        next_flash = (state_next == ST_FL_ENTER) || (state_next == ST_FL) || (state_next == ST_FL_EXIT);
        status_next.switch_en = next_switching;
        status_next.soft_start = (state_next == ST_START);
        status_next.flash_mode = (state_next == ST_FL);
        status_next.standby = (state_next == ST_STANDBY);
        status_next.open_led_fault = (state_next == ST_FAULT);
        status_next.cooldown = (cool_next != 32'h0);
        fs_next = (next_flash && !lock_s) ? FLASH_FS_MV : BACKLIGHT_FS_MV;
        chop_next = (next_switching && dim_s) ? fs_next : 16'h0000;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= '0;
            fs_reg <= BACKLIGHT_FS_MV;
            chop_reg <= 16'h0000;
        end else begin
            status_reg <= status_next;
            fs_reg <= fs_next;
            chop_reg <= chop_next;
        end
    end

    assign status = status_reg;
    assign full_scale_mv = fs_reg;

    // register port
    logic [3:0] cfg_reg, cfg_next;
    logic [31:0] rdata_reg, rdata_next;
    always_comb begin
        cfg_next = (reg_wr && reg_addr == REG_CFG) ? reg_wdata[3:0] : cfg_reg;
        rdata_next = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                REG_CFG: rdata_next = {28'h0, cfg_reg};
                REG_STATUS: rdata_next = (32'(state_reg) << STATUS_STATE_POS) | 32'(status_reg);
                REG_FLASH_TIMER: rdata_next = ftimer_reg;
                REG_COOLDOWN: rdata_next = cool_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= CFG_SHIFT_RESET;
            rdata_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    lbm_ref_filter u_filter (
        .core_clk(core_clk),
        .rst(rst),
        .target(chop_reg),
        .shift(cfg_reg),
        .level(reference_level)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_ovp_last;
        active && sw_tick && ovp_s && ovp_run_reg == OVP_RUN_LAST && !uvlo_s && !otp_s;
    endsequence
    sequence s_fault_out;
        ##1 state_reg == ST_FAULT ##1 status.open_led_fault && !status.switch_en;
    endsequence

    a_ovp_shutdown: assert property (s_ovp_last |-> s_fault_out)
        else $error("open-LED trip did not shut down");
    a_fault_latch: assert property (state_reg == ST_FAULT && !seen_low_reg |=> state_reg == ST_FAULT)
        else $error("fault left without enable toggle");
    a_low_filter: assert property (active && state_next == ST_STANDBY |-> low_cnt_reg >= LOW_DELAY_CYC)
        else $error("standby before enable low time");
    a_flash_scale: assert property (status.flash_mode && !lock_s && !at_limit && !uvlo_s && !otp_s && !ovp_trip
        && !low_expired |=> full_scale_mv == FLASH_FS_MV)
        else $error("flash full scale wrong");
    a_duty_gate: assert property (!dim_s |=> chop_reg == 16'h0000)
        else $error("reference not gated by enable");
    a_uvlo_off: assert property (uvlo_s && state_reg != ST_FAULT
        |=> state_reg == ST_OFF && !status.switch_en)
        else $error("undervoltage did not stop switching");
    a_otp_off: assert property (otp_s && state_reg != ST_FAULT |=> state_reg == ST_OFF)
        else $error("over-temperature did not shut down");
    a_lockout_ref: assert property (lock_s && $past(lock_s) |-> full_scale_mv == BACKLIGHT_FS_MV)
        else $error("flash reference under supply lockout");
    a_timer_up: assert property (in_flash && trig_s && !at_limit && !uvlo_s && !otp_s && !ovp_trip
        |=> ftimer_reg == $past(ftimer_reg) + 32'h3)
        else $error("flash timer did not count up");
    a_limit_return: assert property (in_flash && at_limit && !uvlo_s && !otp_s && !ovp_trip && !low_expired
        |=> state_reg == ST_BL && cool_reg == COOL_DELAY_CYC)
        else $error("flash limit did not force backlight");
    a_cool_block: assert property (state_reg == ST_BL && cool_reg != 32'h0 |=> state_reg != ST_FL_ENTER)
        else $error("flash entered during cool-down");
endmodule : lbm_controller
`default_nettype wire

// *** verif/lbm_host_model.sv ***
// Purpose: host model driving the dimming pwm and the flash trigger pins
// Assumes: one core_clk domain; pwm period scaled down to keep the run short
// Notes: a released or idle pin shows its pull-down level, both pins have one
`timescale 1ns/1ps
`default_nettype none
module lbm_host_model #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // commands from the bench
    input wire logic pwm_on,
    input wire logic [4:0] hi_cyc,
    input wire logic dc_level,
    input wire logic trig,
    // pins toward the controller
    output logic dim_en,
    output logic flash_trig
);
    int phase;

    // low phase stays far below the shutdown delay, so it reads as pwm
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= 0;
            dim_en <= 1'b0;
            flash_trig <= 1'b0;
        end else begin
            phase <= (phase + 1) % PERIOD;
            // duty is set long before any trigger rise
            dim_en <= pwm_on ? (phase < int'(hi_cyc)) : dc_level;
            flash_trig <= trig;
        end
    end
endmodule : lbm_host_model
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the mode controller
// Assumes: shortened delay parameters; one switching cycle is 208 clocks
// Notes: expected values come from integer reckoning in the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lbm_pkg::*;
    localparam int LOW_D = 20;
    localparam int START_D = 30;
    localparam int ENTRY_D = 5;
    localparam int EXIT_D = 5;
    localparam int LIMIT_D = 50;
    localparam int COOL_D = 100;
    localparam int SWC = 208;
    // pwm period prime to the 250-clock filter step, so the filter sees every phase
    localparam int PWM_P = 17;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    lbm_status_t status;
    logic [5:0] st;
    logic [15:0] full_scale_mv;
    logic [15:0] reference_level;
    logic hm_pwm = 1'b0;
    logic [4:0] hm_hi = 5'h10;
    logic hm_lvl = 1'b0;
    logic hm_trig = 1'b0;
    logic dim_en;
    logic flash_trig;
    logic ovp = 1'b0;
    logic uv = 1'b0;
    logic hot = 1'b0;
    logic lock = 1'b0;
    lbm_pins_t pins;
    int n_mismatch = 0;
    int samples_checked = 0;
    integer seed = 32'h14FB09AA;
    int n;
    int exp_ref;
    logic [31:0] d;
    logic [31:0] t1;
    logic [31:0] t2;

    assign pins = '{dim_en, flash_trig, ovp, uv, hot, lock};
    assign st = status;

    lbm_host_model #(.PERIOD(PWM_P)) host (.core_clk(core_clk), .rst(rst), .pwm_on(hm_pwm), .hi_cyc(hm_hi),
        .dc_level(hm_lvl), .trig(hm_trig), .dim_en(dim_en), .flash_trig(flash_trig));

    lbm_controller #(.LOW_DELAY_CYC(32'(LOW_D)), .START_DELAY_CYC(32'(START_D)),
        .ENTRY_DELAY_CYC(32'(ENTRY_D)), .EXIT_DELAY_CYC(32'(EXIT_D)), .FLASH_LIMIT(32'(LIMIT_D)),
        .COOL_DELAY_CYC(32'(COOL_D))) uut (.core_clk(core_clk), .rst(rst), .pins(pins),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .status(status), .full_scale_mv(full_scale_mv),
        .reference_level(reference_level));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick

    // status bits: 5 switch, 4 soft start, 3 flash, 2 standby, 1 fault, 0 cool-down
    task automatic wait_bit(input int b, input logic v, input int lim, output int k);
        k = 0;
        while (st[b] !== v && k < lim) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check(32'(st[b]), 32'(v));
    endtask : wait_bit

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(60000 * 4);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        tick(5);
        rst <= 1'b0;
        check(32'(st), 32'h0);
        check(32'(full_scale_mv), 32'h00C8);
        rd(4'h0, d);
        check(d, 32'h9);
        rd(4'h2, d);
        check(d, 32'h0);
        wr(4'h4, 32'hFFFFFFFF);
        rd(4'h4, d);
        check(d, 32'h0);
        // enable and soft-start
        @(posedge core_clk);
        hm_lvl <= 1'b1;
        wait_bit(5, 1'b1, 10, n);
        check(32'(st[4]), 32'h1);
        wait_bit(4, 1'b0, START_D + 15, n);
        check(32'(n >= START_D - 5), 32'h1);
        rd(4'h4, d);
        check(d, 32'h0000_0220);
        // a low phase shorter than the delay keeps the switch running
        @(posedge core_clk);
        hm_lvl <= 1'b0;
        tick(LOW_D / 2);
        hm_lvl <= 1'b1;
        tick(30);
        check(32'(st[5]), 32'h1);
        // duty gating and filtering: 32-step time constant, about four of them settle it
        wr(4'h0, 32'h5);
        rd(4'h0, d);
        check(d, 32'h5);
        @(posedge core_clk);
        hm_hi <= 5'(8 + ($random(seed) & 7));
        hm_pwm <= 1'b1;
        tick(30000);
        exp_ref = 200 * int'(hm_hi) / PWM_P;
        check(32'(int'(reference_level) >= exp_ref - 20 && int'(reference_level) <= exp_ref + 20), 32'h1);
        check(32'(full_scale_mv), 32'h00C8);
        hm_pwm <= 1'b0;
        // supply lockout keeps the backlight level
        lock <= 1'b1;
        tick(2);
        hm_trig <= 1'b1;
        tick(20);
        check(32'(full_scale_mv), 32'h00C8);
        check(32'(st[3]), 32'h0);
        hm_trig <= 1'b0;
        lock <= 1'b0;
        tick(10);
        // plain flash entry and exit
        hm_trig <= 1'b1;
        tick(8);
        check(32'(full_scale_mv), 32'h03E8);
        wait_bit(3, 1'b1, ENTRY_D + 8, n);
        rd(4'h8, t1);
        tick(10);
        rd(4'h8, t2);
        check(t2 - t1, 32'd36);
        @(posedge core_clk);
        hm_trig <= 1'b0;
        wait_bit(3, 1'b0, EXIT_D + 8, n);
        // exit state still holds the flash level until its delay runs out
        tick(EXIT_D + 2);
        check(32'(full_scale_mv), 32'h00C8);
        rd(4'h8, t1);
        tick(10);
        rd(4'h8, t2);
        check(t1 - t2, 32'd12);
        tick(200);
        // timer limit, forced return and cool-down
        @(posedge core_clk);
        hm_trig <= 1'b1;
        wait_bit(3, 1'b1, ENTRY_D + 8, n);
        wait_bit(3, 1'b0, LIMIT_D + 10, n);
        check(32'(n >= LIMIT_D - 20), 32'h1);
        check(32'(st[0]), 32'h1);
        rd(4'hC, d);
        check(d, 32'(COOL_D - 1));
        @(posedge core_clk);
        hm_trig <= 1'b0;
        tick(5);
        hm_trig <= 1'b1;
        tick(20);
        check(32'(full_scale_mv), 32'h00C8);
        check(32'(st[3]), 32'h0);
        // trigger low inside the cool-down: the timer must drain
        hm_trig <= 1'b0;
        tick(10);
        rd(4'h8, t1);
        tick(10);
        rd(4'h8, t2);
        check(t1 - t2, 32'd12);
        check(32'(st[0]), 32'h1);
        wait_bit(0, 1'b0, COOL_D + 20, n);
        tick(5);
        hm_trig <= 1'b1;
        wait_bit(3, 1'b1, ENTRY_D + 12, n);
        tick(5);
        hm_trig <= 1'b0;
        tick(10);
        // enable low: standby drains the timer, then off
        hm_lvl <= 1'b0;
        wait_bit(2, 1'b1, LOW_D + 15, n);
        check(32'(st[5]), 32'h0);
        wait_bit(2, 1'b0, 200, n);
        rd(4'h4, d);
        check(d, 32'h0);
        // undervoltage and over-temperature
        @(posedge core_clk);
        hm_lvl <= 1'b1;
        wait_bit(5, 1'b1, 10, n);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            if (i == 0) begin
                uv <= 1'b1;
            end else begin
                hot <= 1'b1;
            end
            wait_bit(5, 1'b0, 6, n);
            @(posedge core_clk);
            uv <= 1'b0;
            hot <= 1'b0;
            wait_bit(5, 1'b1, 10, n);
        end
        // overvoltage: a short run does not trip, eight cycles do
        @(posedge core_clk);
        ovp <= 1'b1;
        tick(6 * SWC);
        ovp <= 1'b0;
        tick(300);
        check(32'(st[1]), 32'h0);
        ovp <= 1'b1;
        wait_bit(1, 1'b1, 9 * SWC + 20, n);
        check(32'(n >= 7 * SWC), 32'h1);
        check(32'(st[5]), 32'h0);
        @(posedge core_clk);
        ovp <= 1'b0;
        tick(50);
        check(32'(st[1]), 32'h1);
        hm_lvl <= 1'b0;
        tick(5);
        hm_lvl <= 1'b1;
        wait_bit(1, 1'b0, 15, n);
        wait_bit(5, 1'b1, 15, n);
        tick(10);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
